//--- test/evrc_ext_rail_ctrl_test.sv
// Self-checking bench for the external rail control block
`timescale 1ns/1ps
module evrc_ext_rail_ctrl_test;
  import evrc_pkg::*;
  logic              core_clk  = 1'b0;
  logic              sys_rst   = 1'b1;
  logic              pwrOnRst  = 1'b1;
  logic [ADDR_W-1:0] regAddr   = ADDR_CTRL;
  logic [DATA_W-1:0] regWrData = DATA_ZERO;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  evrc_mode_t        sbcMode   = MODE_INIT;
  logic              batUvPin  = 1'b0;
  logic              heavyLoad = 1'b0;
  logic              overload  = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic              baseCurHighPin;
  logic              shuntOcPin;
  logic              railEnable;
  logic              railLevel3v3;
  logic              hpStageEn;
  logic              lpStageEn;
  logic              ocLimitEn;
  logic              uvShutdownEn;
  int                failCount = 0;
  int                testsRun  = 0;
  int                cyc       = 0;

  always #2 core_clk = ~core_clk;

  evrc_ext_rail_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .pwrOnRst(pwrOnRst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sbcMode(sbcMode), .batUvPin(batUvPin),
    .baseCurHighPin(baseCurHighPin), .shuntOcPin(shuntOcPin), .railEnable(railEnable),
    .railLevel3v3(railLevel3v3), .hpStageEn(hpStageEn), .lpStageEn(lpStageEn),
    .ocLimitEn(ocLimitEn), .uvShutdownEn(uvShutdownEn));

  evrc_rail_model partner (.core_clk(core_clk), .railEnable(railEnable),
    .heavyLoad(heavyLoad), .overload(overload), .baseCurHighPin(baseCurHighPin),
    .shuntOcPin(shuntOcPin));

  task automatic wrapUp();
    if (failCount == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failCount++;
      wrapUp();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Read a register and compare the bits under a mask
  task automatic chkReg(input string what, input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, d & m, exp);
  endtask

  function automatic logic [7:0] outs();
    return {2'b00, railEnable, railLevel3v3, hpStageEn, lpStageEn, ocLimitEn, uvShutdownEn};
  endfunction

  function automatic logic [7:0] rail();
    return {7'b0000000, railEnable};
  endfunction

  task automatic mode(input evrc_mode_t m);
    @(posedge core_clk);
    sbcMode <= m;
    idle(3);
  endtask

  task automatic pins(input logic uv, input logic hv, input logic ol);
    @(posedge core_clk);
    batUvPin  <= uv;
    heavyLoad <= hv;
    overload  <= ol;
    idle(6);
  endtask

  task automatic powerOn();
    @(posedge core_clk);
    pwrOnRst <= 1'b1;
    sys_rst  <= 1'b1;
    repeat (3) @(posedge core_clk);
    pwrOnRst <= 1'b0;
    sys_rst  <= 1'b0;
    idle(1);
  endtask

  task automatic t_standalone();
    chk("outputs after power-on", outs(), DATA_ZERO);
    chkReg("status after power-on", ADDR_STAT, 8'hff, DATA_ZERO);
    chkReg("unmapped read", 8'h7f, 8'hff, DATA_ZERO);
    mode(MODE_NORMAL);
    wr(ADDR_CTRL, 8'h01);
    idle(3);
    chk("stand-alone outputs", outs(), 8'h2b);
    chkReg("stand-alone status", ADDR_STAT, 8'hff, 8'ha3);
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_HWCTRL, 8'h01);
    idle(3);
    chk("3v3 outputs", outs(), 8'h3b);
    chkReg("status after share attempt", ADDR_STAT, 8'hff, 8'ha3);
    mode(MODE_STOP);
    chk("stop fixed outputs", outs(), 8'h37);
    pins(1'b0, 1'b1, 1'b0);
    chk("stop high current", outs(), 8'h3f);
    pins(1'b0, 1'b0, 1'b0);
    chk("stop low current", outs(), 8'h37);
    pins(1'b1, 1'b0, 1'b0);
    chk("rail in undervoltage", rail(), 8'h00);
    pins(1'b0, 1'b0, 1'b0);
    chk("rail after recovery", rail(), 8'h01);
    wr(ADDR_CTRL, 8'h0b);
    pins(1'b1, 1'b0, 1'b0);
    chk("rail with keep-on", rail(), 8'h01);
    pins(1'b0, 1'b0, 1'b1);
    chk("outputs in overcurrent", outs(), 8'h3f);
    wr(ADDR_STAT, 8'h08);
    chkReg("flag while overcurrent", ADDR_STAT, 8'h08, 8'h08);
    pins(1'b0, 1'b0, 1'b0);
    wr(ADDR_STAT, 8'h08);
    chkReg("flag after clear", ADDR_STAT, 8'h08, 8'h00);
    mode(MODE_SLEEP);
    chk("stand-alone sleep", outs(), 8'h37);
    mode(MODE_RESTART);
    chk("stand-alone restart", outs(), 8'h37);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    chkReg("config after soft reset", ADDR_STAT, 8'h86, 8'h82);
    mode(MODE_INIT);
    chk("rail in init", rail(), 8'h00);
  endtask

  task automatic t_share();
    powerOn();
    chkReg("lock after power-on", ADDR_STAT, 8'hff, DATA_ZERO);
    mode(MODE_NORMAL);
    wr(ADDR_HWCTRL, 8'h01);
    wr(ADDR_CTRL, 8'h02);
    idle(3);
    chk("sharing outputs", outs(), 8'h28);
    chkReg("sharing status", ADDR_STAT, 8'hff, 8'ha5);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_HWCTRL, 8'h00);
    idle(3);
    chkReg("status after change attempt", ADDR_STAT, 8'hff, 8'hb5);
    chk("outputs after change attempt", outs(), 8'h28);
    pins(1'b1, 1'b0, 1'b0);
    chk("sharing in undervoltage", outs(), 8'h28);
    pins(1'b0, 1'b0, 1'b1);
    chkReg("flag under sharing", ADDR_STAT, 8'h08, 8'h00);
    pins(1'b0, 1'b0, 1'b0);
    mode(MODE_STOP);
    chk("sharing stop default", rail(), 8'h00);
    chkReg("share bit in stop", ADDR_HWCTRL, 8'h01, 8'h01);
    wr(ADDR_CTRL, 8'h04);
    idle(3);
    chk("sharing stop keep", rail(), 8'h01);
    mode(MODE_SLEEP);
    chk("sharing sleep", rail(), 8'h00);
    mode(MODE_RESTART);
    chk("sharing restart", outs(), 8'h24);
    mode(MODE_FAILSAFE);
    chk("sharing fail-safe", rail(), 8'h00);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    chkReg("share bit after soft reset", ADDR_HWCTRL, 8'h01, 8'h01);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    pwrOnRst <= 1'b0;
    sys_rst  <= 1'b0;
    idle(1);
    t_standalone();
    t_share();
    wrapUp();
  end
endmodule // evrc_ext_rail_ctrl_test

//--- test/evrc_rail_model.sv
// Behavioural model of the external pass transistor and its loads
`timescale 1ns/1ps
module evrc_rail_model (
  input  wire logic core_clk,
  input  wire logic railEnable,
  input  wire logic heavyLoad,
  input  wire logic overload,
  output logic      baseCurHighPin,
  output logic      shuntOcPin
);
  initial baseCurHighPin = 1'b0;
  initial shuntOcPin = 1'b0;
  // Loads draw current only while the rail is on
  always @(posedge core_clk) begin
    baseCurHighPin <= railEnable & (heavyLoad | overload);
    shuntOcPin     <= railEnable & overload;
  end
endmodule // evrc_rail_model

//--- verilog/evrc_ext_rail_ctrl.sv
// Configuration lock and per-mode control of the external-transistor rail
`timescale 1ns/1ps
module evrc_ext_rail_ctrl
  import evrc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              pwrOnRst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  input  wire evrc_mode_t        sbcMode,
  input  wire logic              batUvPin,
  input  wire logic              baseCurHighPin,
  input  wire logic              shuntOcPin,
  output logic                   railEnable,
  output logic                   railLevel3v3,
  output logic                   hpStageEn,
  output logic                   lpStageEn,
  output logic                   ocLimitEn,
  output logic                   uvShutdownEn
);

  logic       anyRst;
  logic [2:0] pinSync;
  logic       batUv;
  logic       baseHigh;
  logic       shuntOc;

  assign anyRst = sys_rst | pwrOnRst;

  evrc_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (anyRst),
    .asyncIn  ({shuntOcPin, baseCurHighPin, batUvPin}),
    .syncOut  (pinSync)
  );

  assign batUv    = pinSync[0];
  assign baseHigh = pinSync[1];
  assign shuntOc  = pinSync[2];

  // Bus decode
  logic wrCtrl;
  logic wrHw;
  logic wrStat;
  assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
  assign wrHw   = regWr && (regAddr == ADDR_HWCTRL);
  assign wrStat = regWr && (regAddr == ADDR_STAT);

  // Configuration state, cleared only by power-on reset
  logic cfgSa_reg;
  logic cfgSa_next;
  logic cfgLs_reg;
  logic cfgLs_next;
  logic locked;

  assign locked = cfgSa_reg | cfgLs_reg;

  always_comb begin
    cfgSa_next = cfgSa_reg;
    cfgLs_next = cfgLs_reg;
    if (!locked) begin
      if (wrCtrl && regWrData[CTRL_SA_ON] && sbcMode == MODE_NORMAL) begin
        cfgSa_next = 1'b1;
      end else if (wrHw && regWrData[HW_LS]) begin
        cfgLs_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (pwrOnRst) begin
      cfgSa_reg <= 1'b0;
      cfgLs_reg <= 1'b0;
    end else begin
      cfgSa_reg <= cfgSa_next;
      cfgLs_reg <= cfgLs_next;
    end
  end

  // Software control bits and flags, cleared by either reset
  evrc_ctrl_t ctrl_reg;
  evrc_ctrl_t ctrl_next;
  logic       lsBit_reg;
  logic       lsBit_next;
  logic       ocFlag_reg;
  logic       ocFlag_next;
  logic       spiFail_reg;
  logic       spiFail_next;
  logic       lsChangeTry;

  // Under locked sharing, a stand-alone request or clearing the share bit
  assign lsChangeTry = cfgLs_reg &&
                       ((wrCtrl && regWrData[CTRL_SA_ON]) ||
                        (wrHw && !regWrData[HW_LS]));

  always_comb begin
    ctrl_next    = ctrl_reg;
    lsBit_next   = lsBit_reg;
    ocFlag_next  = ocFlag_reg;
    spiFail_next = spiFail_reg;
    if (wrCtrl) begin
      ctrl_next.levelSel = regWrData[CTRL_LVL];
      ctrl_next.stopKeep = regWrData[CTRL_STPKEEP];
      ctrl_next.uvKeep   = regWrData[CTRL_UVKEEP];
      // Stand-alone bit only switches the rail in stand-alone or unlocked
      if (!cfgLs_reg && !cfgLs_next) begin
        ctrl_next.standaloneOn = regWrData[CTRL_SA_ON];
      end
    end
    if (wrHw && !cfgSa_reg && !cfgSa_next) begin
      lsBit_next = regWrData[HW_LS] | cfgLs_reg;
    end
    // Locked sharing restores the share bit after a soft reset
    if (cfgLs_reg) begin
      lsBit_next = 1'b1;
    end
    // Write one to clear; the flag is only cleared once the cause is gone
    if (wrStat && regWrData[ST_OC] && !shuntOc) begin
      ocFlag_next = 1'b0;
    end
    if (wrStat && regWrData[ST_SPI_FAIL]) begin
      spiFail_next = 1'b0;
    end
    if (cfgSa_reg && shuntOc) begin
      ocFlag_next = 1'b1;
    end
    if (lsChangeTry) begin
      spiFail_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (anyRst) begin
      ctrl_reg    <= CTRL_RESET;
      lsBit_reg   <= 1'b0;
      ocFlag_reg  <= 1'b0;
      spiFail_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      lsBit_reg   <= lsBit_next;
      ocFlag_reg  <= ocFlag_next;
      spiFail_reg <= spiFail_next;
    end
  end

  // Rail demand: held value carries the Normal-mode setting into fixed modes
  logic heldOn_reg;
  logic heldOn_next;
  logic heldLvl_reg;
  logic heldLvl_next;
  logic modeOn;
  logic uvCut;

  always_comb begin
    heldOn_next  = heldOn_reg;
    heldLvl_next = heldLvl_reg;
    modeOn       = 1'b0;
    if (sbcMode == MODE_NORMAL) begin
      heldOn_next  = cfgSa_reg & ctrl_reg.standaloneOn;
      heldLvl_next = ctrl_reg.levelSel;
    end
    case (sbcMode)
      MODE_INIT: begin
        modeOn = 1'b0;
      end
      MODE_NORMAL: begin
        modeOn = cfgSa_reg ? ctrl_reg.standaloneOn : (cfgLs_reg & lsBit_reg);
      end
      MODE_STOP: begin
        modeOn = cfgSa_reg ? heldOn_reg : (cfgLs_reg & ctrl_reg.stopKeep);
      end
      MODE_SLEEP: begin
        modeOn = cfgSa_reg & heldOn_reg;
      end
      MODE_RESTART: begin
        modeOn = cfgSa_reg ? heldOn_reg : cfgLs_reg;
      end
      MODE_FAILSAFE: begin
        modeOn = 1'b0;
      end
      default: begin
        modeOn = 1'b0;
      end
    endcase
  end

  // Undervoltage cut applies in stand-alone only, restored automatically
  assign uvCut = cfgSa_reg && batUv && !ctrl_reg.uvKeep;

  always_ff @(posedge core_clk) begin
    if (anyRst) begin
      heldOn_reg  <= 1'b0;
      heldLvl_reg <= 1'b0;
    end else begin
      heldOn_reg  <= heldOn_next;
      heldLvl_reg <= heldLvl_next;
    end
  end

  // Output stage
  evrc_rail_t rail_reg;
  evrc_rail_t rail_next;
  logic       lvlSel;

  assign lvlSel = (sbcMode == MODE_NORMAL) ? ctrl_reg.levelSel : heldLvl_reg;

  always_comb begin
    rail_next            = RAIL_OFF;
    rail_next.railOn     = modeOn && !uvCut;
    rail_next.level3v3   = cfgSa_reg && lvlSel;
    rail_next.ocLimit    = cfgSa_reg;
    rail_next.uvShutdown = cfgSa_reg;
    if (rail_next.railOn) begin
      case (sbcMode)
        MODE_NORMAL: begin
          rail_next.hpStage = 1'b1;
          rail_next.lpStage = 1'b0;
        end
        MODE_STOP: begin
          rail_next.hpStage = baseHigh;
          rail_next.lpStage = 1'b1;
        end
        default: begin
          rail_next.hpStage = 1'b0;
          rail_next.lpStage = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (anyRst) begin
      rail_reg <= RAIL_OFF;
    end else begin
      rail_reg <= rail_next;
    end
  end

  assign railEnable   = rail_reg.railOn;
  assign railLevel3v3 = rail_reg.level3v3;
  assign hpStageEn    = rail_reg.hpStage;
  assign lpStageEn    = rail_reg.lpStage;
  assign ocLimitEn    = rail_reg.ocLimit;
  assign uvShutdownEn = rail_reg.uvShutdown;

  // Read data, valid the cycle after the strobe only
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  logic [DATA_W-1:0] statWord;

  always_comb begin
    statWord              = DATA_ZERO;
    statWord[ST_RAIL_ON]  = rail_reg.railOn;
    statWord[ST_CFG_SA]   = cfgSa_reg;
    statWord[ST_CFG_LS]   = cfgLs_reg;
    statWord[ST_OC]       = ocFlag_reg;
    statWord[ST_SPI_FAIL] = spiFail_reg;
    statWord[ST_HP]       = rail_reg.hpStage;
    statWord[ST_BAT_UV]   = batUv;
    statWord[ST_LOCK]     = locked;
    rdData_next           = DATA_ZERO;
    if (regRd) begin
      case (regAddr)
        ADDR_CTRL: begin
          rdData_next[CTRL_SA_ON]   = ctrl_reg.standaloneOn;
          rdData_next[CTRL_LVL]     = ctrl_reg.levelSel;
          rdData_next[CTRL_STPKEEP] = ctrl_reg.stopKeep;
          rdData_next[CTRL_UVKEEP]  = ctrl_reg.uvKeep;
        end
        ADDR_HWCTRL: begin
          rdData_next[HW_LS] = lsBit_reg;
        end
        ADDR_STAT: begin
          rdData_next = statWord;
        end
        default: begin
          rdData_next = DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (anyRst) begin
      rdData_reg <= DATA_ZERO;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // Checks
  AST_SA_SELECT: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (!locked && wrCtrl && regWrData[CTRL_SA_ON] && sbcMode == MODE_NORMAL)
      |=> cfgSa_reg && !cfgLs_reg)
    else $error("Stand-alone not selected after enable write in Normal");

  AST_LS_SELECT: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (!locked && wrHw && regWrData[HW_LS] && !(wrCtrl))
      |=> cfgLs_reg)
    else $error("Load sharing not selected after share bit write");

  AST_LOCK_STABLE: assert property (
    @(posedge core_clk) disable iff (pwrOnRst)
    locked |=> $stable(cfgSa_reg) && $stable(cfgLs_reg))
    else $error("Locked configuration changed");

  AST_SOFT_RESET_KEEPS: assert property (
    @(posedge core_clk) disable iff (pwrOnRst)
    (sys_rst && locked) |=> locked)
    else $error("Soft reset cleared the configuration lock");

  AST_LEVEL: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (cfgSa_reg && sbcMode == MODE_NORMAL && $stable(sbcMode))
      |=> railLevel3v3 == $past(ctrl_reg.levelSel))
    else $error("Output level does not follow select bit");

  AST_LS_LEVEL: assert property (
    @(posedge core_clk) disable iff (anyRst)
    cfgLs_reg |=> !railLevel3v3)
    else $error("Level select honoured under load sharing");

  AST_MODE_OFF: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (sbcMode == MODE_INIT || sbcMode == MODE_FAILSAFE) |=> !railEnable)
    else $error("Rail on in Init or Fail-Safe");

  AST_LS_SLEEP: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (cfgLs_reg && sbcMode == MODE_SLEEP) |=> !railEnable)
    else $error("Shared rail on in Sleep");

  AST_LS_STOP: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (cfgLs_reg && sbcMode == MODE_STOP)
      |=> railEnable == $past(ctrl_reg.stopKeep) && lsBit_reg)
    else $error("Stop-mode load sharing wrong");

  AST_UV_CUT: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (cfgSa_reg && batUv && !ctrl_reg.uvKeep) |=> !railEnable)
    else $error("Rail left on in undervoltage");

  AST_NORMAL_HP: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (sbcMode == MODE_NORMAL && $stable(sbcMode)) ##1 railEnable
      |-> hpStageEn && !lpStageEn)
    else $error("Stage selection wrong in Normal");

  AST_STOP_HP: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (sbcMode == MODE_STOP && rail_next.railOn) |=> hpStageEn == $past(baseHigh))
    else $error("High-power stage not following base current");

  AST_UV_ONLY_SA: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (cfgLs_reg && sbcMode == MODE_NORMAL && lsBit_reg && $stable(sbcMode)) |=> railEnable)
    else $error("Undervoltage cut applied under load sharing");

  AST_OC_ONLY_SA: assert property (
    @(posedge core_clk) disable iff (anyRst)
    ocLimitEn |-> cfgSa_reg && !cfgLs_reg)
    else $error("Overcurrent limit enabled outside stand-alone");

  AST_LS_NO_OC: assert property (
    @(posedge core_clk) disable iff (anyRst)
    cfgLs_reg |-> !ocLimitEn && !ocFlag_reg)
    else $error("Overcurrent limit or flag active under load sharing");

  AST_OC_STICKY: assert property (
    @(posedge core_clk) disable iff (anyRst)
    (cfgSa_reg && shuntOc) |=> ocFlag_reg)
    else $error("Overcurrent flag not set");

  AST_SPI_FAIL: assert property (
    @(posedge core_clk) disable iff (anyRst)
    lsChangeTry |=> spiFail_reg && cfgLs_reg && !cfgSa_reg)
    else $error("Change attempt under locked sharing not flagged");

  AST_POR_CLEAR: assert property (
    @(posedge core_clk)
    pwrOnRst |=> !locked && !railEnable)
    else $error("Power-on reset left configuration or rail");

endmodule // evrc_ext_rail_ctrl

//--- verilog/evrc_pkg.sv
// Constants and types for the external-transistor rail control block
package evrc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_HWCTRL = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_STAT   = 8'h02;

  // Control register fields
  localparam int CTRL_SA_ON   = 0;
  localparam int CTRL_LVL     = 1;
  localparam int CTRL_STPKEEP = 2;
  localparam int CTRL_UVKEEP  = 3;
  // Hardware control register field
  localparam int HW_LS        = 0;
  // Status register fields
  localparam int ST_RAIL_ON   = 0;
  localparam int ST_CFG_SA    = 1;
  localparam int ST_CFG_LS    = 2;
  localparam int ST_OC        = 3;
  localparam int ST_SPI_FAIL  = 4;
  localparam int ST_HP        = 5;
  localparam int ST_BAT_UV    = 6;
  localparam int ST_LOCK      = 7;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // Chip operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_INIT     = 6'h01,
    MODE_NORMAL   = 6'h02,
    MODE_STOP     = 6'h04,
    MODE_SLEEP    = 6'h08,
    MODE_RESTART  = 6'h10,
    MODE_FAILSAFE = 6'h20
  } evrc_mode_t;

  typedef struct packed {
    logic uvKeep;
    logic stopKeep;
    logic levelSel;
    logic standaloneOn;
  } evrc_ctrl_t;

  localparam evrc_ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic railOn;
    logic level3v3;
    logic hpStage;
    logic lpStage;
    logic ocLimit;
    logic uvShutdown;
  } evrc_rail_t;

  localparam evrc_rail_t RAIL_OFF = '0;

endpackage

//--- verilog/evrc_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module evrc_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          meta_reg[i] <= 1'b0;
          syncOut[i]  <= 1'b0;
        end else begin
          meta_reg[i] <= asyncIn[i];
          syncOut[i]  <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule // evrc_sync
